// File: pkg/apss_pkg.sv
// Shared constants and carriers for the power-state sequencer.
// Assumes a single 250 MHz standby clock; long press times are counted in milliseconds by a tick.
package apss_pkg;

	// System states; the processor-stopped state is deliberately absent.
	typedef enum logic [1:0] {
		APSS_S0,
		APSS_S3,
		APSS_S4,
		APSS_S5
	} apss_state_t;

	// Wake sources after synchronising, one bit each.
	typedef struct packed {
		logic pwr_sw;
		logic rtc_alarm;
		logic lan_wake;
		logic pcie_wake;
		logic usb_act;
		logic serial_act;
	} apss_wake_t;

	// Power controls driven toward the supply and the board.
	typedef struct packed {
		logic main_rails_on;
		logic fan_en;
		logic usb_pwr_en;
		logic dev_pwr_en;
		logic power_led;
	} apss_pwr_t;

	// Operating-system requests, one-cycle pulses from logic on the same clock.
	typedef struct packed {
		logic sleep_s3;
		logic sleep_s4;
		logic soft_off;
	} apss_os_req_t;

	localparam int unsigned APSS_CLK_HZ       = 250_000_000;
	localparam int unsigned APSS_MS_PER_S     = 1000;
	localparam int unsigned APSS_SHORT_S      = 4;
	localparam int unsigned APSS_LONG_S       = 6;
	localparam int unsigned APSS_SHORT_MS     = APSS_SHORT_S * APSS_MS_PER_S;
	localparam int unsigned APSS_LONG_MS      = APSS_LONG_S * APSS_MS_PER_S;
	localparam int unsigned APSS_TICK_CYCLES  = APSS_CLK_HZ / APSS_MS_PER_S;
	localparam int unsigned APSS_PRESS_W      = 13;

endpackage : apss_pkg

// File: rtl/apss_sequencer.sv
// Power-state sequencer: switch timing, wake acceptance, power gating and AC-loss restore.
// Assumes core_clk runs from standby power and rst is raised on standby power-up.
//
// Behaviour
// - A press shorter than four seconds moves soft-off or sleep to working, and working to sleep when sw_sleep_cfg is set.
// - A press held past six seconds in working or sleep forces soft-off.
// - Only suspend-to-RAM, suspend-to-disk and soft-off are entered, never a processor-stopped state.
// - In suspend-to-RAM, suspend-to-disk and soft-off device power is off apart from wake logic.
// - The switch, the alarm and the network wake each wake from all three low states.
// - The add-in card wake line wakes from all three low states.
// - USB activity wakes only from suspend-to-RAM, and USB is unpowered in the deeper states.
// - USB power is off in suspend-to-disk and soft-off.
// - Serial activity wakes only from suspend-to-RAM.
// - A detected network wake frame raises a wake request that powers the system up.
// - Fans run in the working state.
// - Fans stop in every low state.
// - A soft-off command turns every main rail off while standby stays.
// - After AC returns, the prior on or off state is restored subject to a last-state setting.
// - In suspend-to-RAM the supply is off, the power indicator follows a setting, and any wake returns to work.
`timescale 1ns/1ps
module apss_sequencer
	import apss_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = APSS_TICK_CYCLES,
	parameter int unsigned SHORT_MS    = APSS_SHORT_MS,
	parameter int unsigned LONG_MS     = APSS_LONG_MS
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         pwr_sw_n,
	input  wire logic         rtc_alarm,
	input  wire logic         lan_wake_frame,
	input  wire logic         pcie_wake_n,
	input  wire logic         usb_activity,
	input  wire logic         serial_activity,
	input  wire apss_os_req_t os_req,
	input  wire logic         sw_sleep_cfg,
	input  wire logic [1:0]   last_state_cfg,
	input  wire logic         prior_on,
	input  wire logic         sleep_led_behavior,
	input  wire logic         led_blink,
	output apss_pwr_t         pwr,
	output apss_state_t       sys_state,
	output logic              lan_wake_req
);
	// Last-state setting codes: stay off, turn on, or restore what was held.
	localparam logic [1:0] LAST_OFF     = 2'h0;
	localparam logic [1:0] LAST_ON      = 2'h1;
	localparam logic [1:0] LAST_RESTORE = 2'h2;

	// Refuse timings that the press counter cannot hold or that leave no gap between the thresholds.
	if (SHORT_MS == 0 || LONG_MS <= SHORT_MS || LONG_MS >= (1 << APSS_PRESS_W)
	    || TICK_CYCLES < 2) begin : g_bad_timing
		$error("apss_sequencer: bad press timing parameters");
	end

	typedef struct packed {
		apss_state_t          state;
		logic [31:0]          tick_cnt;
		logic [APSS_PRESS_W-1:0] press_ms;
		logic                 pressed;
		logic                 long_done;
		logic                 boot_done;
		apss_pwr_t            pwr;
		logic                 lan_req;
	} apss_st_t;

	apss_st_t   st_q;
	apss_st_t   st_d;
	apss_wake_t wk;
	logic [5:0] raw_sync;
	logic       tick;
	logic       release_ev;
	logic       short_press;
	logic       long_hit;
	logic       any_wake;

	// Every pin-side source crosses two flops before the state logic reads it.
	apss_sync #(.WIDTH(6)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({~pwr_sw_n, rtc_alarm, lan_wake_frame, ~pcie_wake_n, usb_activity, serial_activity}),
		.sync_out (raw_sync)
	);
	assign wk = apss_wake_t'(raw_sync);

	// Millisecond enable from the standby clock divider.
	assign tick        = (st_q.tick_cnt == 32'(TICK_CYCLES - 1));
	assign release_ev  = st_q.pressed && !wk.pwr_sw;
	assign short_press = release_ev && !st_q.long_done && (st_q.press_ms < APSS_PRESS_W'(SHORT_MS));
	assign long_hit    = st_q.pressed && wk.pwr_sw && !st_q.long_done && tick
	                     && (st_q.press_ms == APSS_PRESS_W'(LONG_MS - 1));

	// Wake acceptance per low state; the switch wakes through its short press instead of its level.
	always_comb begin
		any_wake = 1'b0;
		case (st_q.state)
			APSS_S3: any_wake = wk.rtc_alarm || st_q.lan_req || wk.pcie_wake
			                    || wk.usb_act || wk.serial_act;
			APSS_S4,
			APSS_S5: any_wake = wk.rtc_alarm || st_q.lan_req || wk.pcie_wake;
			default: any_wake = 1'b0;
		endcase
	end

	always_comb begin
		st_d = st_q;
		// Divider runs continuously; a press started mid-period costs at most one millisecond.
		st_d.tick_cnt = tick ? 32'h0 : st_q.tick_cnt + 32'h1;
		// Network wake request stands while a frame is flagged and the system is low.
		st_d.lan_req = wk.lan_wake && (st_q.state != APSS_S0);
		// Press timing saturates so a very long hold never wraps back into a short press.
		if (wk.pwr_sw && !st_q.pressed) begin
			st_d.pressed  = 1'b1;
			st_d.press_ms = '0;
		end else if (release_ev) begin
			st_d.pressed   = 1'b0;
			st_d.long_done = 1'b0;
		end else if (st_q.pressed && tick && st_q.press_ms != APSS_PRESS_W'(LONG_MS)) begin
			st_d.press_ms = st_q.press_ms + APSS_PRESS_W'(1);
		end
		if (long_hit) begin
			st_d.long_done = 1'b1;
		end

		if (!st_q.boot_done) begin
			// First cycle after standby power-up decides the AC-loss restore.
			st_d.boot_done = 1'b1;
			case (last_state_cfg)
				LAST_OFF:     st_d.state = APSS_S5;
				LAST_ON:      st_d.state = APSS_S0;
				LAST_RESTORE: st_d.state = prior_on ? APSS_S0 : APSS_S5;
				default:      st_d.state = APSS_S5;
			endcase
		end else if (long_hit && st_q.state != APSS_S5) begin
			st_d.state = APSS_S5;
		end else begin
			case (st_q.state)
				APSS_S0: begin
					if (os_req.soft_off) begin
						st_d.state = APSS_S5;
					end else if (os_req.sleep_s4) begin
						st_d.state = APSS_S4;
					end else if (os_req.sleep_s3 || (short_press && sw_sleep_cfg)) begin
						st_d.state = APSS_S3;
					end
				end
				APSS_S3,
				APSS_S4,
				APSS_S5: begin
					if (short_press || any_wake) begin
						st_d.state = APSS_S0;
					end
				end
				default: st_d.state = APSS_S5;
			endcase
		end

		// Outputs follow the state being entered, so they are flop outputs.
		st_d.pwr.main_rails_on = (st_d.state == APSS_S0);
		st_d.pwr.dev_pwr_en    = (st_d.state == APSS_S0);
		st_d.pwr.fan_en        = (st_d.state == APSS_S0);
		st_d.pwr.usb_pwr_en    = (st_d.state == APSS_S0) || (st_d.state == APSS_S3);
		case (st_d.state)
			APSS_S0: st_d.pwr.power_led = 1'b1;
			APSS_S3: st_d.pwr.power_led = sleep_led_behavior & led_blink;
			default: st_d.pwr.power_led = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q       <= '0;
			st_q.state <= APSS_S5;
		end else begin
			st_q <= st_d;
		end
	end

	assign pwr          = st_q.pwr;
	assign sys_state    = st_q.state;
	assign lan_wake_req = st_q.lan_req;

	// Checks.
	sequence s_short_release;
		short_press && st_q.boot_done && !long_hit;
	endsequence

	a_short_wakes: assert property (@(posedge core_clk) disable iff (rst)
		s_short_release and (st_q.state != APSS_S0) |=> (st_q.state == APSS_S0))
		else $error("short press did not wake");
	a_long_off: assert property (@(posedge core_clk) disable iff (rst)
		long_hit && st_q.boot_done && st_q.state != APSS_S5 |=> (st_q.state == APSS_S5) && !pwr.main_rails_on)
		else $error("long press did not force soft-off");
	a_sw_cfg_gate: assert property (@(posedge core_clk) disable iff (rst)
		s_short_release and (st_q.state == APSS_S0) and !sw_sleep_cfg and os_req == '0 |=> st_q.state == APSS_S0)
		else $error("switch slept without configuration");
	a_dev_pwr_low: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state != APSS_S0) |-> !pwr.dev_pwr_en && !pwr.main_rails_on)
		else $error("device power on in a low state");
	a_wake_pcie: assert property (@(posedge core_clk) disable iff (rst)
		st_q.boot_done && wk.pcie_wake && st_q.state != APSS_S0 && !long_hit |=> st_q.state == APSS_S0)
		else $error("card wake ignored");
	a_usb_deep: assert property (@(posedge core_clk) disable iff (rst)
		st_q.boot_done && st_q.state == APSS_S4 && $stable(st_q.state) && wk.usb_act && !wk.rtc_alarm
		&& !wk.pcie_wake && !st_q.lan_req && !short_press |=> st_q.state == APSS_S4)
		else $error("usb woke from suspend-to-disk");
	a_usb_off: assert property (@(posedge core_clk) disable iff (rst)
		(st_q.state == APSS_S4 || st_q.state == APSS_S5) |-> !pwr.usb_pwr_en)
		else $error("usb powered in deep state");
	a_fan_state: assert property (@(posedge core_clk) disable iff (rst)
		st_q.boot_done |-> pwr.fan_en == (st_q.state == APSS_S0))
		else $error("fan does not follow state");
	a_soft_off: assert property (@(posedge core_clk) disable iff (rst)
		st_q.boot_done && st_q.state == APSS_S0 && os_req.soft_off |=> st_q.state == APSS_S5 ##0 !pwr.main_rails_on)
		else $error("soft-off command ignored");

	// The indicator flop takes the setting one cycle before it shows the sleep state.
	sequence s_led_cfg_off;
		!sleep_led_behavior ##1 st_q.state == APSS_S3;
	endsequence

	a_led_sleep: assert property (@(posedge core_clk) disable iff (rst)
		s_led_cfg_off |-> !pwr.power_led)
		else $error("power indicator lit against the sleep setting");
	a_serial_deep: assert property (@(posedge core_clk) disable iff (rst)
		st_q.boot_done && (st_q.state == APSS_S4 || st_q.state == APSS_S5) && wk.serial_act && !wk.rtc_alarm
		&& !wk.pcie_wake && !st_q.lan_req && !short_press |=> st_q.state != APSS_S0)
		else $error("serial activity woke from a deep state");
	a_restore_on: assert property (@(posedge core_clk) disable iff (rst)
		!st_q.boot_done && last_state_cfg == LAST_ON |=> st_q.state == APSS_S0)
		else $error("last-state on setting not honoured");
	a_restore_prior: assert property (@(posedge core_clk) disable iff (rst)
		!st_q.boot_done && last_state_cfg == LAST_RESTORE && prior_on |=> st_q.state == APSS_S0)
		else $error("prior on state not restored");
endmodule : apss_sequencer

// File: rtl/apss_sync.sv
// Two-flip-flop synchroniser for a vector of asynchronous levels.
// Assumes the inputs are slow levels; pulses shorter than one clock may be missed.
`timescale 1ns/1ps
module apss_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} apss_sync_st_t;

	apss_sync_st_t st_q;
	apss_sync_st_t st_d;

	// Only the second stage is visible outside.
	always_comb begin
		st_d.meta   = async_in;
		st_d.stable = st_q.meta;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.stable;
endmodule : apss_sync

// File: tb/apss_partner.sv
// Far-side model: the front power switch and the wake sources.
// Assumes the bench calls its tasks; every pin changes on a falling edge only.
`timescale 1ns/1ps
module apss_partner (
	input  wire logic core_clk,
	output logic       pwr_sw_n,
	output logic [4:0] wake
);
	// Idle: the switch line sits at its pull-up and every wake source is quiet.
	initial begin
		pwr_sw_n = 1'b1;
		wake     = 5'h00;
	end

	// Hold the switch for a number of cycles, then release it to the pull-up level.
	task automatic press(input int cyc);
		@(negedge core_clk) pwr_sw_n = 1'b0;
		repeat (cyc) @(negedge core_clk);
		pwr_sw_n = 1'b1;
	endtask : press

	// Raise one wake source long enough to clear the synchroniser, then drop it.
	// Bit 1 is a detected network wake frame; bit 2 is inverted on its way to the card pin.
	task automatic raise(input int idx);
		@(negedge core_clk) wake[idx] = 1'b1;
		repeat (6) @(negedge core_clk);
		wake[idx] = 1'b0;
	endtask : raise
endmodule : apss_partner

// File: tb/tb.sv
// Self-checking bench for the power-state sequencer with shortened press times.
// Assumes the partner drives switch and wakes; bench inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
	import apss_pkg::*;
	logic         core_clk           = 1'b0;
	logic         rst                = 1'b1;
	logic         pwr_sw_n;
	logic [4:0]   wake;
	apss_os_req_t os_req;
	logic         sw_sleep_cfg;
	logic [1:0]   last_state_cfg;
	logic         prior_on;
	logic         sleep_led_behavior;
	logic         led_blink;
	apss_pwr_t    pwr;
	apss_state_t  sys_state;
	logic         lan_wake_req;
	int           n_mismatch         = 0;
	int           n_tests            = 0;
	int           cycles             = 0;
	int           n_lan              = 0;

	// A millisecond tick lasts 4 cycles here, so a short press is under 16 cycles and a long one over 24.
	apss_sequencer #(.TICK_CYCLES(4), .SHORT_MS(4), .LONG_MS(6)) uut (
		.core_clk(core_clk), .rst(rst), .pwr_sw_n(pwr_sw_n), .rtc_alarm(wake[0]),
		.lan_wake_frame(wake[1]), .pcie_wake_n(~wake[2]), .usb_activity(wake[3]),
		.serial_activity(wake[4]), .os_req(os_req), .sw_sleep_cfg(sw_sleep_cfg),
		.last_state_cfg(last_state_cfg), .prior_on(prior_on), .sleep_led_behavior(sleep_led_behavior),
		.led_blink(led_blink), .pwr(pwr), .sys_state(sys_state), .lan_wake_req(lan_wake_req));
	apss_partner far (.core_clk(core_clk), .pwr_sw_n(pwr_sw_n), .wake(wake));

	// Clock at 250 MHz.
	always #2 core_clk = ~core_clk;

	// Counts settled cycles with the network wake request up, so a short pulse is not missed.
	always @(negedge core_clk) begin
		if (lan_wake_req === 1'b1) n_lan++;
	end

	// Watchdog: the whole run needs well under 3000 cycles, so a hang is cut at 6000.
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// Every answer lands within four edges of its cause, so eight cycles is a safe settle time.
	task automatic settle();
		repeat (8) @(negedge core_clk);
	endtask : settle

	// One-cycle request pulse: 0 soft-off, 1 suspend-to-disk, 2 suspend-to-RAM.
	task automatic os(input int k);
		@(negedge core_clk) os_req = apss_os_req_t'(3'h1 << k);
		@(negedge core_clk) os_req = '0;
		settle();
	endtask : os

	task automatic do_reset(input logic [1:0] cfg, input logic prior);
		@(negedge core_clk) rst = 1'b1;
		last_state_cfg = cfg;
		prior_on       = prior;
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		settle();
	endtask : do_reset

	task automatic check_on();
		`CHK(sys_state, APSS_S0)
		`CHK(pwr.fan_en, 1'b1)
		`CHK(pwr.main_rails_on, 1'b1)
		`CHK(pwr.dev_pwr_en, 1'b1)
		`CHK(pwr.power_led, 1'b1)
	endtask : check_on

	task automatic check_low(input apss_state_t s);
		`CHK(sys_state, s)
		`CHK(pwr.fan_en, 1'b0)
		`CHK(pwr.dev_pwr_en, 1'b0)
		`CHK(pwr.main_rails_on, 1'b0)
		`CHK(pwr.usb_pwr_en, (s == APSS_S3))
	endtask : check_low

	// Short presses walk off, on, sleep, on; the unconfigured switch must not sleep.
	task automatic t_switch();
		far.press(8);
		settle();
		check_on();
		sw_sleep_cfg = 1'b0;
		far.press(8);
		settle();
		`CHK(sys_state, APSS_S0)
		sw_sleep_cfg = 1'b1;
		far.press(8);
		settle();
		check_low(APSS_S3);
		`CHK(pwr.power_led, 1'b1)
		led_blink = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK(pwr.power_led, 1'b0)
		led_blink          = 1'b1;
		sleep_led_behavior = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK(pwr.power_led, 1'b0)
		sleep_led_behavior = 1'b1;
		far.press(8);
		settle();
		check_on();
	endtask : t_switch

	// Each source from suspend-to-RAM, then from suspend-to-disk where USB and serial are refused.
	task automatic t_wakes();
		int lan_base;
		for (int i = 0; i < 5; i++) begin
			os(2);
			check_low(APSS_S3);
			lan_base = n_lan;
			far.raise(i);
			settle();
			`CHK(sys_state, APSS_S0)
			`CHK(n_lan != lan_base, (i == 1))
		end
		for (int i = 0; i < 5; i++) begin
			os(1);
			check_low(APSS_S4);
			lan_base = n_lan;
			far.raise(i);
			settle();
			`CHK(sys_state, (i < 3) ? APSS_S0 : APSS_S4)
			`CHK(n_lan != lan_base, (i == 1))
		end
		// Requests are ignored outside working, so leave suspend-to-disk by the switch first.
		far.press(8);
		settle();
		check_on();
		os(0);
		check_low(APSS_S5);
		far.raise(2);
		settle();
		`CHK(sys_state, APSS_S0)
	endtask : t_wakes

	// A release between the thresholds is ignored; a long hold forces soft-off from work and sleep.
	task automatic t_long();
		far.press(18);
		settle();
		`CHK(sys_state, APSS_S0)
		far.press(40);
		settle();
		check_low(APSS_S5);
		far.press(8);
		settle();
		os(2);
		far.press(40);
		settle();
		`CHK(sys_state, APSS_S5)
	endtask : t_long

	// Main sequence, ending with the last-state restore settings after fresh resets.
	initial begin
		os_req             = '0;
		sw_sleep_cfg       = 1'b1;
		last_state_cfg     = 2'h0;
		prior_on           = 1'b0;
		sleep_led_behavior = 1'b1;
		led_blink          = 1'b1;
		do_reset(2'h0, 1'b0);
		check_low(APSS_S5);
		t_switch();
		t_wakes();
		t_long();
		do_reset(2'h1, 1'b0);
		check_on();
		do_reset(2'h2, 1'b1);
		check_on();
		do_reset(2'h2, 1'b0);
		`CHK(sys_state, APSS_S5)
		do_reset(2'h3, 1'b1);
		`CHK(sys_state, APSS_S5)
		tally_and_finish();
	end
endmodule : tb
